// *** verilog/slave_parallel_host_port.sv ***
// Slave parallel host port with host-mode general-purpose fallback.
`timescale 1ns/100ps
`default_nettype none
`include "host_port_params.svh"
module slave_parallel_host_port
   import host_port_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Port C pins.
   input wire logic [`DATA_W-1:0] data_bus_pins_in,
   output logic [`DATA_W-1:0] data_bus_pins_out,
   output logic [`DATA_W-1:0] data_bus_pins_oe_out,
   // Port D pins 0 to 5.
   input wire logic [`PD_W-1:0] portd_pins_in,
   output logic [`PD_W-1:0] portd_pins_out,
   output logic [`PD_W-1:0] portd_pins_oe_out,
   // Core side, port C.
   input wire logic [`DATA_W-1:0] core_portc_data_in,
   input wire logic [`DATA_W-1:0] core_portc_dir_in,
   input wire logic core_out_latch_wr_in,
   input wire logic core_in_latch_rd_in,
   output logic [`DATA_W-1:0] core_portc_read_out,
   // Core side, port D.
   input wire logic [`PD_W-1:0] core_portd_data_in,
   input wire logic [`PD_W-1:0] core_portd_dir_in,
   output logic [`PD_W-1:0] core_portd_read_out,
   // Mode and interrupts.
   output logic slave_mode_out,
   output logic host_write_irq_out,
   output logic host_read_irq_out,
   output logic spare_gpio_lo_irq_out,
   output logic spare_gpio_hi_irq_out
);
   // ==========================================================
   // Reset release
   logic rst_meta_n;
   logic rst_n;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_n <= 1'h0;
         rst_n <= 1'h0;
      end else begin
         rst_meta_n <= 1'h1;
         rst_n <= rst_meta_n;
      end
   end

   // ==========================================================
   // Pin synchronisation for port D pins 2 to 5
   wire [`SYNC_W-1:0] pd_raw = portd_pins_in[`PD_SPARE_HI:`PD_STROBE];
   logic [`SYNC_W-1:0] pd_level;
   logic [`SYNC_W-1:0] pd_rise;
   logic [`SYNC_W-1:0] pd_fall;

   pin_sync_edge #(
      .W(`SYNC_W)
   ) pin_sync_edge_i (
      .clk_in(sys_clk_in),
      .rst_n_in(rst_n),
      .pin_in(pd_raw),
      .level_out(pd_level),
      .rise_out(pd_rise),
      .fall_out(pd_fall)
   );

   // ==========================================================
   // Mode strap
   // The mode is caught once after reset: a host idling its strobe high selects slave mode.
   port_mode_t mode;
   wire strobe_idle_high = pd_level[`SY_STROBE];
   logic [1:0] strap_wait;
   wire strap_ready = strap_wait[1];
   wire is_slave = (mode == MODE_SLAVE);
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         mode <= MODE_STRAP;
         strap_wait <= 2'h0;
      end else begin
         strap_wait <= {strap_wait[0], 1'h1};
         unique case (mode)
            MODE_STRAP: begin
               if (strap_ready) begin
                  mode <= strobe_idle_high ? MODE_SLAVE : MODE_HOST;
               end
            end
            MODE_HOST: mode <= MODE_HOST;
            MODE_SLAVE: mode <= MODE_SLAVE;
         endcase
      end
   end

   // ==========================================================
   // Handshake decode
   wire strobe_low = ~pd_level[`SY_STROBE];
   wire dir_read_high = pd_level[`SY_DIR];
   wire strobe_rise = pd_rise[`SY_STROBE];
   wire write_done = is_slave & strobe_rise & ~dir_read_high;
   wire read_done = is_slave & strobe_rise & dir_read_high;
   wire host_reading = is_slave & strobe_low & dir_read_high;

   // ==========================================================
   // Latches and ready flags
   logic [`DATA_W-1:0] in_latch;
   logic [`DATA_W-1:0] out_latch;
   logic host_may_write_n;
   logic host_may_read_n;
   logic [`DATA_W-1:0] bus_capture;
   // A host write finishing in the same cycle as a core read keeps the latch full.
   wire next_may_write_n = write_done ? 1'h1 :
      (core_in_latch_rd_in ? 1'h0 : host_may_write_n);
   // A core write in the same cycle as a host read end leaves the new byte waiting.
   wire next_may_read_n = (is_slave & core_out_latch_wr_in) ? 1'h0 :
      (read_done ? 1'h1 : host_may_read_n);
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         bus_capture <= `BYTE_RST;
         in_latch <= `BYTE_RST;
      end else begin
         bus_capture <= data_bus_pins_in;
         if (write_done) begin
            in_latch <= bus_capture;
         end
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         out_latch <= `BYTE_RST;
      end else if (core_out_latch_wr_in) begin
         out_latch <= core_portc_data_in;
      end
   end

   // ==========================================================
   // Ready flags
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         host_may_write_n <= `WR_RDY_RST;
         host_may_read_n <= `RD_RDY_RST;
      end else begin
         host_may_write_n <= next_may_write_n;
         host_may_read_n <= next_may_read_n;
      end
   end

   // ==========================================================
   // Pin drive selection
   wire [`DATA_W-1:0] next_pc_out = is_slave ? out_latch : core_portc_data_in;
   wire [`DATA_W-1:0] next_pc_oe = is_slave ? {`DATA_W{host_reading}} :
      core_portc_dir_in;
   // The flag pins take the next flag value so they move in the same cycle as the interrupts.
   wire [`PD_W-1:0] slave_pd_out = {core_portd_data_in[`PD_SPARE_HI:`PD_SPARE_LO],
      2'h0, next_may_read_n, next_may_write_n};
   wire [`PD_W-1:0] slave_pd_oe = {core_portd_dir_in[`PD_SPARE_HI:`PD_SPARE_LO],
      2'h0, 2'h3};
   wire [`PD_W-1:0] next_pd_out = is_slave ? slave_pd_out : core_portd_data_in;
   wire [`PD_W-1:0] next_pd_oe = (mode == MODE_STRAP) ? `PD_RST :
      (is_slave ? slave_pd_oe : core_portd_dir_in);
   wire [`DATA_W-1:0] next_pc_read = is_slave ? in_latch : bus_capture;

   // ==========================================================
   // Interrupts: rising on pins 2 and 4, falling on pins 3 and 5; in slave mode the pin 2 and 3 interrupts are write and read strobe rises
   // The pad input is used, so edges count whether the pin is an input or an output.
   wire next_irq_d2 = is_slave ? write_done : (mode == MODE_HOST) & pd_rise[`SY_STROBE];
   wire next_irq_d3 = is_slave ? read_done : (mode == MODE_HOST) & pd_fall[`SY_DIR];
   wire next_irq_d4 = (mode != MODE_STRAP) & pd_rise[`SY_SPARE_LO];
   wire next_irq_d5 = (mode != MODE_STRAP) & pd_fall[`SY_SPARE_HI];

   // ==========================================================
   // Port C pin registers
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         data_bus_pins_out <= `BYTE_RST;
         data_bus_pins_oe_out <= `BYTE_RST;
      end else begin
         data_bus_pins_out <= next_pc_out;
         data_bus_pins_oe_out <= next_pc_oe;
      end
   end

   // ==========================================================
   // Port D pin registers
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         portd_pins_out <= `PD_RST;
         portd_pins_oe_out <= `PD_RST;
      end else begin
         portd_pins_out <= next_pd_out;
         portd_pins_oe_out <= next_pd_oe;
      end
   end

   // ==========================================================
   // Core read-back and mode registers
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         core_portc_read_out <= `BYTE_RST;
         core_portd_read_out <= `PD_RST;
         slave_mode_out <= 1'h0;
      end else begin
         core_portc_read_out <= next_pc_read;
         core_portd_read_out <= portd_pins_in;
         slave_mode_out <= is_slave;
      end
   end

   // ==========================================================
   // Interrupt registers
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         host_write_irq_out <= 1'h0;
         host_read_irq_out <= 1'h0;
         spare_gpio_lo_irq_out <= 1'h0;
         spare_gpio_hi_irq_out <= 1'h0;
      end else begin
         host_write_irq_out <= next_irq_d2;
         host_read_irq_out <= next_irq_d3;
         spare_gpio_lo_irq_out <= next_irq_d4;
         spare_gpio_hi_irq_out <= next_irq_d5;
      end
   end
endmodule // slave_parallel_host_port
`default_nettype wire

// *** verilog/host_port_params.svh ***
// Constants for the slave parallel host port.
// Contract
// - Slave mode is chosen only by handshake pin levels, never by software.
// - In slave mode port D pins 0-3 are write-ready, read-ready, strobe, direction.
// - In slave mode port C is the host data bus, moving bytes to and from latches.
// - In slave mode only port D pins 4 and 5 stay general I/O with interrupts.
// - In host mode six pins act as port D 0-5, eight as port C.
// - Transitions on port D pins 2-5 raise interrupts whatever the pin direction.
// - Drive host_may_write_n low while the input latch is free.
// - Strobe rise in a write latches data, raises host_may_write_n, pulses host_write_irq.
// - A core read of the input latch returns host_may_write_n low.
// - Drive host_may_read_n low while a core byte waits in the output latch.
// - Host reads with direction high and strobe low; device drives the output latch.
// - Strobe rise in a read raises host_may_read_n, floats the bus, pulses host_read_irq.
// - A core write to the output latch drives host_may_read_n low again.
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

// ==========================================================
// Port D pin positions
`define PD_WR_RDY 0
`define PD_RD_RDY 1
`define PD_STROBE 2
`define PD_DIR 3
`define PD_SPARE_LO 4
`define PD_SPARE_HI 5

// ==========================================================
// Positions in the synchronised pin vector (port D pins 2 to 5)
`define SY_STROBE 0
`define SY_DIR 1
`define SY_SPARE_LO 2
`define SY_SPARE_HI 3

// ==========================================================
// Widths and reset values
`define DATA_W 8
`define PD_W 6
`define SYNC_W 4
`define SYNC_PRIME 3
`define WR_RDY_RST 1'h0
`define RD_RDY_RST 1'h1
`define BYTE_RST 8'h00
`define PD_RST 6'h00

`endif

// *** verilog/host_port_pkg.sv ***
// Types shared by the slave parallel host port.
`default_nettype none
package host_port_pkg;
   typedef enum logic [1:0] {MODE_STRAP, MODE_HOST, MODE_SLAVE} port_mode_t;
endpackage
`default_nettype wire

// *** verilog/pin_sync_edge.sv ***
// Two-flop pin synchroniser with registered edge pulses.
`timescale 1ns/100ps
`default_nettype none
`include "host_port_params.svh"
module pin_sync_edge #(
   parameter int W = 4
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level_out,
   output logic [W-1:0] rise_out,
   output logic [W-1:0] fall_out
);
   logic [W-1:0] meta;
   logic [W-1:0] stable;
   logic [W-1:0] prev;
   logic [`SYNC_PRIME-1:0] primed;
   // Until prev holds a real pin level, a pin idling high would look like a fresh rising edge.
   wire edge_ok = primed[`SYNC_PRIME-1];
   wire [W-1:0] next_rise = stable & ~prev & {W{edge_ok}};
   wire [W-1:0] next_fall = ~stable & prev & {W{edge_ok}};

   // ==========================================================
   // Synchroniser and edge detection
   // Edges are taken only from the second stage; the first stage is never looked at.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta <= '0;
         stable <= '0;
         prev <= '0;
         primed <= '0;
         rise_out <= '0;
         fall_out <= '0;
      end else begin
         primed <= {primed[`SYNC_PRIME-2:0], 1'h1};
         meta <= pin_in;
         stable <= meta;
         prev <= stable;
         rise_out <= next_rise;
         fall_out <= next_fall;
      end
   end

   assign level_out = stable;
endmodule // pin_sync_edge
`default_nettype wire

// *** tb/host_port_props.sv ***
// Concurrent checks on the slave parallel host port pins.
`timescale 1ns/100ps
`default_nettype none
module host_port_props (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic [5:0] portd_pins_out,
   input wire logic [5:0] portd_pins_oe_out,
   input wire logic [7:0] data_bus_pins_oe_out,
   input wire logic [5:0] core_portd_dir_in,
   input wire logic core_in_latch_rd_in,
   input wire logic core_out_latch_wr_in,
   input wire logic slave_mode_out,
   input wire logic host_write_irq_out,
   input wire logic host_read_irq_out
);
   // ==========================================================
   // Properties
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   AST_WR_IRQ: assert property (slave_mode_out && host_write_irq_out |-> portd_pins_out[0])
      else $error("write irq without full flag");
   AST_RD_IRQ: assert property (slave_mode_out && host_read_irq_out |->
      portd_pins_out[1] && data_bus_pins_oe_out == 8'h00)
      else $error("read irq with flag low or bus driven");
   AST_IN_FREE: assert property (slave_mode_out && core_in_latch_rd_in |->
      ##1 (!portd_pins_out[0] || host_write_irq_out))
      else $error("write flag not freed after core read");
   AST_OUT_FULL: assert property (slave_mode_out && core_out_latch_wr_in |->
      ##1 !portd_pins_out[1])
      else $error("read flag not set after core write");
   AST_PIN_ROLE: assert property (slave_mode_out && $past(slave_mode_out) |->
      portd_pins_oe_out[3:0] == 4'h3)
      else $error("handshake pin drive wrong");
   AST_SPARE_DIR: assert property (slave_mode_out && $past(slave_mode_out) |->
      portd_pins_oe_out[5:4] == $past(core_portd_dir_in[5:4]))
      else $error("spare pin direction not followed");
   AST_WR_RISE: assert property (slave_mode_out && $past(slave_mode_out) &&
      $rose(portd_pins_out[0]) |-> host_write_irq_out)
      else $error("write flag rose without irq");
   AST_RD_RISE: assert property (slave_mode_out && $past(slave_mode_out) &&
      $rose(portd_pins_out[1]) |-> host_read_irq_out)
      else $error("read flag rose without irq");
   AST_MODE_HOLD: assert property ($past(slave_mode_out) |-> slave_mode_out)
      else $error("slave mode dropped");
endmodule // host_port_props
`default_nettype wire

// *** tb/host_model.sv ***
// Behavioural host processor on the far side of the port.
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input wire logic clk_in,
   input wire logic [7:0] dev_out_in,
   input wire logic [7:0] dev_oe_in,
   input wire logic [1:0] rdy_n_in,
   output logic [7:0] pad_out,
   output logic strobe_out,
   output logic dir_out
);
   logic [7:0] hdat = 8'h00;
   logic [7:0] last = 8'h00;
   logic hdrv = 1'b0;
   // A released bus shows the inverse of its last level.
   assign pad_out = (dev_oe_in != 8'h00) ? dev_out_in : (hdrv ? hdat : ~last);
   always @(posedge clk_in) last <= pad_out;
   initial begin strobe_out = 1'b1; dir_out = 1'b0; end
   task automatic set_pins(input logic s, input logic d);
      @(posedge clk_in); strobe_out <= s; dir_out <= d;
   endtask
   task automatic wr(input logic [7:0] b);
      for (int i = 0; i < 50 && rdy_n_in[0]; i++) @(posedge clk_in);
      @(posedge clk_in); dir_out <= 1'b0; hdrv <= 1'b1; hdat <= b;
      repeat (4) @(posedge clk_in); strobe_out <= 1'b0;
      repeat (5) @(posedge clk_in); strobe_out <= 1'b1;
      repeat (5) @(posedge clk_in); hdrv <= 1'b0;
   endtask
   task automatic rd(output logic [7:0] b);
      for (int i = 0; i < 50 && rdy_n_in[1]; i++) @(posedge clk_in);
      @(posedge clk_in); dir_out <= 1'b1;
      repeat (4) @(posedge clk_in); strobe_out <= 1'b0;
      repeat (7) @(posedge clk_in); b = pad_out; strobe_out <= 1'b1;
      repeat (7) @(posedge clk_in);
   endtask
endmodule // host_model
`default_nettype wire

// *** tb/slave_parallel_host_port_tb.sv ***
// Self-checking bench for the slave parallel host port.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin \
   num_checks++; \
   if ((g) !== (e)) begin \
      n_fail++; \
      $display("[ERR] %s exp %h got %h", n, e, g); \
   end \
end
module slave_parallel_host_port_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] pc_out, pc_oe, pc_pad, c_data = 8'h00, c_dir = 8'h00, c_rd;
   logic [5:0] pd_out, pd_oe, pd_in, d_data = 6'h00, d_dir = 6'h00, d_rd;
   logic [1:0] spare = 2'h0;
   logic wr_p = 1'b0, rd_p = 1'b0, slave, irq_w, irq_r, irq_lo, irq_hi, strobe, dir;
   logic [7:0] got;
   int n_fail = 0, num_checks = 0;
   int cnt[4] = '{0, 0, 0, 0};
   assign pd_in = {pd_oe[5] ? pd_out[5] : spare[1], pd_oe[4] ? pd_out[4] : spare[0], dir, strobe,
      pd_out[1:0]};
   slave_parallel_host_port slave_parallel_host_port_i (.sys_clk_in(clk), .rst_n_in(rst_n),
      .data_bus_pins_in(pc_pad), .data_bus_pins_out(pc_out), .data_bus_pins_oe_out(pc_oe),
      .portd_pins_in(pd_in), .portd_pins_out(pd_out), .portd_pins_oe_out(pd_oe),
      .core_portc_data_in(c_data), .core_portc_dir_in(c_dir), .core_out_latch_wr_in(wr_p),
      .core_in_latch_rd_in(rd_p), .core_portc_read_out(c_rd), .core_portd_data_in(d_data),
      .core_portd_dir_in(d_dir), .core_portd_read_out(d_rd), .slave_mode_out(slave),
      .host_write_irq_out(irq_w), .host_read_irq_out(irq_r), .spare_gpio_lo_irq_out(irq_lo),
      .spare_gpio_hi_irq_out(irq_hi));
   host_model host_model_i (.clk_in(clk), .dev_out_in(pc_out), .dev_oe_in(pc_oe),
      .rdy_n_in(pd_out[1:0]), .pad_out(pc_pad), .strobe_out(strobe), .dir_out(dir));
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) begin
      cnt[0] <= cnt[0] + int'(irq_w);
      cnt[1] <= cnt[1] + int'(irq_r);
      cnt[2] <= cnt[2] + int'(irq_lo);
      cnt[3] <= cnt[3] + int'(irq_hi);
   end
   task automatic pulse(input logic load_out);
      @(posedge clk);
      wr_p <= load_out;
      rd_p <= ~load_out;
      @(posedge clk);
      wr_p <= 1'b0;
      rd_p <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic do_reset(input logic s);
      host_model_i.set_pins(s, 1'b0); rst_n <= 1'b0; repeat (5) @(posedge clk); rst_n <= 1'b1;
      repeat (12) @(posedge clk); #1;
   endtask
   task automatic t_write;
      `CHK("slave", 1'b1, slave)
      `CHK("wr_rdy", 1'b0, pd_out[0])
      host_model_i.wr(8'hA5); #1;
      `CHK("wr_irq", 1, cnt[0])
      `CHK("wr_full", 1'b1, pd_out[0])
      `CHK("in_latch", 8'hA5, c_rd)
      pulse(1'b0);
      #1;
      `CHK("wr_free", 1'b0, pd_out[0])
      $display("write test done");
   endtask
   task automatic t_read;
      `CHK("rd_empty", 1'b1, pd_out[1])
      c_data <= 8'h3C;
      pulse(1'b1);
      #1;
      `CHK("rd_ready", 1'b0, pd_out[1])
      host_model_i.rd(got); #1;
      `CHK("rd_data", 8'h3C, got)
      `CHK("rd_irq", 1, cnt[1])
      `CHK("rd_done", 1'b1, pd_out[1])
      `CHK("rd_float", 8'h00, pc_oe)
      $display("read test done");
   endtask
   task automatic t_spare;
      @(posedge clk); spare <= 2'h2; repeat (3) @(posedge clk); spare <= 2'h1;
      repeat (8) @(posedge clk); #1;
      `CHK("lo_irq", 1, cnt[2])
      `CHK("hi_irq", 1, cnt[3])
      @(posedge clk);
      d_dir <= 6'h10;
      repeat (8) @(posedge clk);
      #1;
      `CHK("spare_oe", 6'h13, pd_oe)
      @(posedge clk);
      d_data <= 6'h10;
      repeat (8) @(posedge clk);
      #1;
      `CHK("lo_irq_out", 2, cnt[2])
      $display("spare test done");
   endtask
   task automatic t_host;
      d_data <= 6'h01;
      d_dir <= 6'h03;
      c_dir <= 8'hFF;
      do_reset(1'b0);
      `CHK("host_mode", 1'b0, slave)
      `CHK("host_oe", 6'h03, pd_oe)
      `CHK("host_pins", 2'h1, pd_out[1:0])
      `CHK("host_pc_oe", 8'hFF, pc_oe)
      `CHK("host_pc_out", 8'h3C, pc_out)
      `CHK("host_pc_rd", 8'h3C, c_rd)
      host_model_i.set_pins(1'b1, 1'b1); repeat (8) @(posedge clk);
      host_model_i.set_pins(1'b1, 1'b0); repeat (8) @(posedge clk); #1;
      `CHK("host_edges", 2, cnt[0] + cnt[1])
      `CHK("host_pd_rd", 6'h15, d_rd)
      $display("host mode test done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      do_reset(1'b1); t_write(); t_read(); t_spare();
      cnt = '{0, 0, 0, 0}; t_host(); finish_test();
   end
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      finish_test();
   end
endmodule // slave_parallel_host_port_tb
bind slave_parallel_host_port host_port_props host_port_props_i (.*);
`default_nettype wire
